/* File: cdt_addr_calc.v */
`timescale 1ns/1ps
`default_nettype none
module cdt_addr_calc (
    input  wire [31:0] base_value,
    input  wire [7:0]  word_offset,
    input  wire        up_bit,
    input  wire        pre_bit,
    output wire [31:0] first_addr,
    output wire [31:0] modified_base
);
`include "cdt_defines.vh"
    wire [31:0] byte_ofs;
    assign byte_ofs      = {24'h000000, word_offset} << `CDT_OFS_SHIFT;
    assign modified_base = up_bit ? base_value + byte_ofs
                                  : base_value - byte_ofs;
    assign first_addr    = pre_bit ? modified_base : base_value;
endmodule // cdt_addr_calc
`default_nettype wire

/* File: cdt_agu.v */
`timescale 1ns/1ps
`default_nettype none
`include "cdt_defines.vh"
module cdt_agu #(
    parameter CNT_W = 8
) (
    input  wire        clk,
    input  wire        rst,
    input  wire        start,
    input  wire [31:0] instr,
    input  wire        cond_pass,
    input  wire [31:0] instr_addr,
    input  wire [31:0] base_reg_value,
    input  wire        cp_absent,
    input  wire        cp_busy,
    input  wire        cp_last,
    input  wire        mem_abort,
    output reg  [31:0] mem_addr_ff,
    output reg         mem_req_ff,
    output reg         mem_write_ff,
    output reg         mem_seq_ff,
    output reg  [1:0]  cycle_type_ff,
    output reg         cp_go_ff,
    output reg         long_xfer_ff,
    output reg  [3:0]  coprocessor_number_field_ff,
    output reg  [3:0]  coproc_first_register_field_ff,
    output reg         wb_en_ff,
    output reg  [3:0]  wb_reg_ff,
    output reg  [31:0] wb_value_ff,
    output reg         data_abort_ff,
    output reg         undef_ff,
    output reg         done_ff,
    output reg         busy_ff,
    output reg  [CNT_W-1:0] words_ff,
    output reg  [CNT_W-1:0] wait_cycles_ff,
    output reg  [CNT_W-1:0] total_cycles_ff
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_XFER = 2'h2;

    reg  [1:0]  state_ff;
    reg  [31:0] mod_base_ff;
    reg         wb_req_ff;
    reg  [3:0]  base_reg_field_ff;
    reg         aborted_ff;
    reg  [1:0]  nxt_state;

    wire [3:0]  base_register_field;
    wire [31:0] base_value;
    wire [31:0] first_addr;
    wire [31:0] modified_base;
    wire        pc_base;

    assign base_register_field = instr[`CDT_RN_MSB:`CDT_RN_LSB];
    assign pc_base    = (base_register_field == `CDT_PC_REG);
    assign base_value = pc_base ? instr_addr + `CDT_PC_BIAS : base_reg_value;

    cdt_addr_calc u_calc (
        .base_value    (base_value),
        .word_offset   (instr[`CDT_OFS_MSB:`CDT_OFS_LSB]),
        .up_bit        (instr[`CDT_BIT_U]),
        .pre_bit       (instr[`CDT_BIT_P]),
        .first_addr    (first_addr),
        .modified_base (modified_base)
    );

    // Cost counters stick at all ones rather than wrap on a very long busy-wait
    function [CNT_W-1:0] cnt_add;
        input [CNT_W-1:0] value;
        input [1:0]       step;
        reg   [CNT_W:0]   sum;
        begin
            sum     = {1'b0, value} + {{(CNT_W-1){1'b0}}, step};
            cnt_add = sum[CNT_W] ? {CNT_W{1'b1}} : sum[CNT_W-1:0];
        end
    endfunction

    // Next state kept apart; only state_ff follows it, the output flops decode state_ff and the inputs
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start && cond_pass)
                    nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (cp_absent)
                    nxt_state = ST_IDLE;
                else if (!cp_busy)
                    nxt_state = ST_XFER;
            end
            ST_XFER: begin
                if (cp_last)
                    nxt_state = ST_IDLE;
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge clk) begin
        if (rst) begin
            state_ff                       <= ST_IDLE;
            mem_addr_ff                    <= 32'h00000000;
            mem_req_ff                     <= 1'b0;
            mem_write_ff                   <= 1'b0;
            mem_seq_ff                     <= 1'b0;
            cycle_type_ff                  <= `CDT_CYC_I;
            cp_go_ff                       <= 1'b0;
            long_xfer_ff                   <= 1'b0;
            coprocessor_number_field_ff    <= 4'h0;
            coproc_first_register_field_ff <= 4'h0;
            wb_en_ff                       <= 1'b0;
            wb_reg_ff                      <= 4'h0;
            wb_value_ff                    <= 32'h00000000;
            data_abort_ff                  <= 1'b0;
            undef_ff                       <= 1'b0;
            done_ff                        <= 1'b0;
            busy_ff                        <= 1'b0;
            words_ff                       <= {CNT_W{1'b0}};
            wait_cycles_ff                 <= {CNT_W{1'b0}};
            total_cycles_ff                <= {CNT_W{1'b0}};
            mod_base_ff                    <= 32'h00000000;
            wb_req_ff                      <= 1'b0;
            base_reg_field_ff              <= 4'h0;
            aborted_ff                     <= 1'b0;
        end else begin
            done_ff       <= 1'b0;
            wb_en_ff      <= 1'b0;
            data_abort_ff <= 1'b0;
            undef_ff      <= 1'b0;
            state_ff      <= nxt_state;
            case (state_ff)
                ST_IDLE: begin
                    mem_req_ff <= 1'b0;
                    if (start && cond_pass) begin
                        coprocessor_number_field_ff    <= instr[`CDT_CPN_MSB:`CDT_CPN_LSB];
                        coproc_first_register_field_ff <= instr[`CDT_CRD_MSB:`CDT_CRD_LSB];
                        long_xfer_ff      <= instr[`CDT_BIT_N];
                        mem_write_ff      <= ~instr[`CDT_BIT_L];
                        // Post-index alone never writes back; PC never written back
                        wb_req_ff         <= instr[`CDT_BIT_W] & ~pc_base;
                        mod_base_ff       <= modified_base;
                        base_reg_field_ff <= base_register_field;
                        mem_addr_ff       <= first_addr;
                        cp_go_ff          <= 1'b1;
                        busy_ff           <= 1'b1;
                        aborted_ff        <= 1'b0;
                        words_ff          <= {CNT_W{1'b0}};
                        wait_cycles_ff    <= {CNT_W{1'b0}};
                        total_cycles_ff   <= {CNT_W{1'b0}};
                        cycle_type_ff     <= `CDT_CYC_I;
                    end else if (start) begin
                        done_ff <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (cp_absent) begin
                        // No coprocessor claimed the number: hand off, no access
                        undef_ff <= 1'b1;
                        done_ff  <= 1'b1;
                        cp_go_ff <= 1'b0;
                        busy_ff  <= 1'b0;
                    end else if (cp_busy) begin
                        wait_cycles_ff  <= cnt_add(wait_cycles_ff, `CDT_CNT_STEP);
                        total_cycles_ff <= cnt_add(total_cycles_ff, `CDT_CNT_STEP);
                        cycle_type_ff   <= `CDT_CYC_I;
                    end else begin
                        mem_req_ff    <= 1'b1;
                        mem_seq_ff    <= 1'b0;
                        cycle_type_ff <= `CDT_CYC_N;
                    end
                end
                ST_XFER: begin
                    words_ff        <= cnt_add(words_ff, `CDT_CNT_STEP);
                    total_cycles_ff <= cnt_add(total_cycles_ff, `CDT_CNT_STEP);
                    if (mem_abort)
                        aborted_ff <= 1'b1;
                    if (cp_last) begin
                        // Final N cycle covers the internal step after the last word
                        mem_req_ff      <= 1'b0;
                        cycle_type_ff   <= `CDT_CYC_N;
                        total_cycles_ff <= cnt_add(total_cycles_ff, `CDT_LAST_COST);
                        wb_en_ff        <= wb_req_ff;
                        wb_reg_ff       <= base_reg_field_ff;
                        wb_value_ff     <= mod_base_ff;
                        data_abort_ff   <= aborted_ff | mem_abort;
                        cp_go_ff        <= 1'b0;
                        busy_ff         <= 1'b0;
                        done_ff         <= 1'b1;
                    end else begin
                        mem_addr_ff   <= mem_addr_ff + `CDT_WORD_STEP;
                        mem_seq_ff    <= 1'b1;
                        cycle_type_ff <= `CDT_CYC_S;
                    end
                end
                // An illegal code drops the request and the claim at once
                default: begin
                    mem_req_ff <= 1'b0;
                    cp_go_ff   <= 1'b0;
                    busy_ff    <= 1'b0;
                end
            endcase
        end
    end
endmodule // cdt_agu
`default_nettype wire

/* File: cdt_agu_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, seen, exp) begin comparisons++; if ((seen) !== (exp)) begin failures++; \
    $display("Error %s expected %h seen %h", nm, exp, seen); end end
module cdt_agu_bench;
    logic            clk = 1'b0, rst = 1'b1, start = 1'b0, cond_pass = 1'b0;
    logic [31:0]     instr = 32'h0, instr_addr = 32'h0, base_reg_value = 32'h0;
    logic [7:0]      busy_n = 8'h00, words_n = 8'h01, abort_w = 8'hFF;
    wire logic       cp_absent, cp_busy, cp_last, mem_abort, mem_req_ff, mem_write_ff;
    wire logic       mem_seq_ff, cp_go_ff, long_xfer_ff, wb_en_ff, data_abort_ff;
    wire logic       undef_ff, done_ff, busy_ff;
    wire logic [31:0] mem_addr_ff, wb_value_ff;
    wire logic [1:0] cycle_type_ff;
    wire logic [3:0] coprocessor_number_field_ff, coproc_first_register_field_ff, wb_reg_ff;
    wire logic [7:0] words_ff, wait_cycles_ff, total_cycles_ff;
    int              failures = 0, comparisons = 0, cycles = 0;
    cdt_agu u_dut (.*);
    cdt_cop_model u_cop (.go(cp_go_ff), .req(mem_req_ff), .lng(long_xfer_ff),
                         .cpn(coprocessor_number_field_ff), .*);
    always #12.5 clk = ~clk;
    function automatic logic [31:0] mk(input logic [4:0] mode, input logic [3:0] rn, cpn,
                                       input logic [7:0] off);
        mk = {4'hE, 3'b110, mode, rn, 4'h2, cpn, off};
    endfunction
    task automatic run(input logic [31:0] ins, input logic cp, input logic [31:0] bv,
                       input logic [7:0] b, n, ab, input logic xu);
        logic [31:0] bs, md, ad;
        logic [7:0]  nn;
        logic        go, wbe;
        int          k, w;
        nn = ins[22] ? n : 8'h01;
        go = cp && !xu;
        wbe = go && ins[21] && ins[19:16] != 4'hF;
        bs = ins[19:16] == 4'hF ? bv + 32'h48 : bv;
        md = ins[23] ? bs + {22'h0, ins[7:0], 2'h0} : bs - {22'h0, ins[7:0], 2'h0};
        ad = ins[24] ? md : bs;
        // Gap lets the coprocessor see the idle cycle and clear its counts
        repeat (2) @(negedge clk);
        instr = ins;
        cond_pass = cp;
        base_reg_value = bv;
        instr_addr = bv + 32'h40;
        busy_n = b;
        words_n = n;
        abort_w = ab;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        k = 0;
        w = 0;
        while (done_ff !== 1'b1 && undef_ff !== 1'b1 && k < 300) begin
            if (mem_req_ff === 1'b1) begin
                `CHK("addr", mem_addr_ff, ad)
                `CHK("type", cycle_type_ff, w == 0 ? 2'h1 : 2'h2)
                `CHK("dir", mem_write_ff, !ins[20])
                ad = ad + 32'h4;
                w++;
            end
            @(negedge clk);
            k++;
        end
        `CHK("done", done_ff, 1'b1)
        `CHK("undef", undef_ff, xu)
        `CHK("nwords", w, go ? int'(nn) : 0)
        `CHK("wb", wb_en_ff, wbe)
        `CHK("abort", data_abort_ff, go && ab < nn)
        if (cp) begin
            `CHK("cpnum", coprocessor_number_field_ff, ins[11:8])
            `CHK("first", coproc_first_register_field_ff, ins[15:12])
            `CHK("long", long_xfer_ff, ins[22])
        end
        if (wbe) begin
            `CHK("wbval", wb_value_ff, md)
            `CHK("wbreg", wb_reg_ff, ins[19:16])
        end
        if (go) begin
            `CHK("waits", wait_cycles_ff, b)
            `CHK("words", words_ff, nn)
            `CHK("total", total_cycles_ff, b + nn + 8'h01)
        end
    endtask
    task print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        rst = 1'b0;
        run(mk(5'b11011, 4'h3, 4'h6, 8'h05), 1'b1, 32'h1000, 8'h00, 8'h01, 8'hFF, 1'b0);
        run(mk(5'b00100, 4'h4, 4'h6, 8'hFF), 1'b1, 32'h2002, 8'h02, 8'h03, 8'hFF, 1'b0);
        run(mk(5'b10011, 4'hF, 4'h6, 8'h02), 1'b1, 32'h3000, 8'h01, 8'h01, 8'hFF, 1'b0);
        repeat (2)
            run(mk(5'b01110, 4'h5, 4'h6, 8'h06), 1'b1, 32'h4000, 8'h00, 8'h04, 8'h01, 1'b0);
        run(mk(5'b11011, 4'h3, 4'h6, 8'h01), 1'b0, 32'h5000, 8'h00, 8'h01, 8'hFF, 1'b0);
        run(mk(5'b11011, 4'h3, 4'h9, 8'h01), 1'b1, 32'h6000, 8'h00, 8'h01, 8'hFF, 1'b1);
        print_verdict();
    end
endmodule // cdt_agu_bench
`default_nettype wire

/* File: cdt_agu_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module cdt_agu_properties #(
    parameter CNT_W = 8
) (
    input wire logic             clk, rst, start, cond_pass, cp_busy, cp_absent, cp_last,
    input wire logic             cp_go_ff, busy_ff, mem_req_ff, mem_seq_ff, done_ff, wb_en_ff,
    input wire logic [31:0]      mem_addr_ff,
    input wire logic [1:0]       cycle_type_ff,
    input wire logic [3:0]       wb_reg_ff,
    input wire logic [CNT_W-1:0] words_ff, wait_cycles_ff, total_cycles_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    skip_cond_a: assert property (start && !busy_ff && !cond_pass
        |=> done_ff && !mem_req_ff && !wb_en_ff) else $error("skipped instruction acted");
    seq_step_a: assert property (mem_req_ff && !cp_last
        |=> mem_req_ff && mem_seq_ff && mem_addr_ff == $past(mem_addr_ff) + 32'h4)
        else $error("next word address not four higher");
    first_nseq_a: assert property ($rose(mem_req_ff)
        |-> cycle_type_ff == 2'h1 && !mem_seq_ff) else $error("first word not non-sequential");
    later_seq_a: assert property (mem_req_ff && !cp_last |=> cycle_type_ff == 2'h2)
        else $error("later word not sequential");
    addr_owner_a: assert property (mem_req_ff |-> cp_go_ff && busy_ff)
        else $error("address issued outside a transfer");
    wait_hold_a: assert property (busy_ff && !mem_req_ff && cp_busy |=> !mem_req_ff)
        else $error("address issued while coprocessor busy");
    accept_go_a: assert property (busy_ff && !mem_req_ff && !cp_busy && !cp_absent
        |=> mem_req_ff) else $error("no address after accept");
    end_done_a: assert property (mem_req_ff && cp_last
        |=> done_ff && !mem_req_ff && !busy_ff) else $error("last word did not end");
    cost_sum_a: assert property (mem_req_ff && cp_last
        |=> total_cycles_ff == wait_cycles_ff + words_ff + 1) else $error("cycle cost wrong");
    pc_nowb_a: assert property (wb_en_ff |-> wb_reg_ff != 4'hF)
        else $error("write-back to program counter");
    cover property (mem_req_ff && cp_last && mem_seq_ff);
    cover property (busy_ff && cp_busy);
    cover property (wb_en_ff);
    cover property (busy_ff && !mem_req_ff && cp_absent);
endmodule // cdt_agu_properties
bind cdt_agu cdt_agu_properties #(.CNT_W(CNT_W)) u_props (.*);
`default_nettype wire

/* File: cdt_cop_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cdt_cop_model #(
    parameter logic [3:0] OWN_NUM = 4'h6
) (
    input wire logic       clk, go, req, lng,
    input wire logic [3:0] cpn,
    input wire logic [7:0] busy_n, words_n, abort_w,
    output logic           cp_absent, cp_busy, cp_last, mem_abort
);
    logic [7:0] bc_ff, wc_ff;
    wire        mine = cpn == OWN_NUM;
    // Counts restart each instruction, so a retried transfer replays exactly
    always @(posedge clk) begin
        if (!go) begin
            bc_ff <= 8'h00;
            wc_ff <= 8'h00;
        end else if (!req)
            bc_ff <= bc_ff + 8'h01;
        else
            wc_ff <= wc_ff + 8'h01;
    end
    assign cp_absent = go && !req && !mine;
    assign cp_busy = go && !req && mine && bc_ff < busy_n;
    assign cp_last = req && wc_ff == (lng ? words_n - 8'h01 : 8'h00);
    assign mem_abort = req && wc_ff == abort_w;
endmodule // cdt_cop_model
`default_nettype wire

/* File: cdt_defines.vh */
`ifndef CDT_DEFINES_VH
`define CDT_DEFINES_VH
`define CDT_OFS_LSB      0
`define CDT_OFS_MSB      7
`define CDT_OFS_SHIFT    2
`define CDT_WORD_STEP    32'h00000004
`define CDT_PC_BIAS      32'h00000008
`define CDT_PC_REG       4'hF
`define CDT_BIT_L        20
`define CDT_BIT_W        21
`define CDT_BIT_N        22
`define CDT_BIT_U        23
`define CDT_BIT_P        24
`define CDT_RN_LSB       16
`define CDT_RN_MSB       19
`define CDT_CRD_LSB      12
`define CDT_CRD_MSB      15
`define CDT_CPN_LSB      8
`define CDT_CPN_MSB      11
`define CDT_CYC_I        2'h0
`define CDT_CYC_N        2'h1
`define CDT_CYC_S        2'h2
`define CDT_CNT_STEP     2'h1
`define CDT_LAST_COST    2'h2
`endif
